// ==== hdl/rst_pkg.sv ====
// package for the reset and start-up sequencer: constants, types, register map
// assumes a 20 MHz sys_clk and an apb master in front of the register file
// Functional notes
// - one of four oscillator modes, picked by a two-bit select field
// - crystal modes also accept an external clock on the oscillator input pin
// - seven reset causes: power-on, clear run, clear sleep, watchdog, watchdog wake, brown-out, interrupt wake
// - uninitialised registers get no reset load; they keep contents
// - resettable registers load reset state on every reset cause except wake
// - watchdog wake-up from sleep resumes operation without a reset load
// - timeout and power-down flags are set by cause so software can tell
// - external clear passes a noise filter that ignores short pulses
// - watchdog reset is internal; external clear pin is never driven low
// - supply rise detection raises an internal power-on reset pulse
// - power-up timer delays 72 ms only after power-on or brown-out
// - power-up timer counts ticks of a dedicated internal rc oscillator
// - device stays in reset while the power-up timer counts
// - a configuration bit enables or disables the power-up timer
// - start-up timer counts 1024 oscillator cycles after power-up delay, holding reset
// - start-up count only in crystal modes, on power-on or wake from sleep
// - select field: 11 rc, 10 high-speed, 01 crystal/resonator, 00 low-power
// - power-up timer enable bit is active low
// - flags: 1,1 power-on; 0,1 watchdog; 0,0 watchdog wake; 1,0 clear in sleep
// - brown-out enable forces the power-up timer on
package rst_pkg;
  localparam int PUT_MS = 72;
  localparam int RC_OSC_KHZ = 1000;
  localparam int PUT_TICKS = PUT_MS * RC_OSC_KHZ;
  localparam int SUT_CYCLES = 1024;
  localparam int FILT_TICKS = 4;
  localparam int CNT_W = 24;
  localparam int SUT_W = 11;
  localparam int FILT_W = 8;

  // apb register map
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  // config field positions and reset value
  localparam int CFG_OSC_LO = 0;
  localparam int CFG_PUT_EN_N = 2;
  localparam int CFG_BROWN_EN = 3;
  localparam logic [3:0] CFG_RST = 4'h7;
  // status field positions
  localparam int ST_PDOWN = 0;
  localparam int ST_TMO = 1;
  localparam int ST_CAUSE = 2;
  localparam int ST_INRST = 5;

  // synchronised pin positions
  localparam int PIN_CLR = 0;
  localparam int PIN_RC = 1;
  localparam int PIN_OSC = 2;
  localparam int PIN_WDOG = 3;
  localparam int PIN_BROWN = 4;
  localparam int PIN_SUP = 5;
  localparam int PIN_N = 6;

  typedef enum logic [1:0] {
    OSC_LOW_POWER = 2'h0,
    OSC_CRYSTAL = 2'h1,
    OSC_HIGH_SPEED = 2'h2,
    OSC_RC = 2'h3
  } rst_osc_mode_t;

  typedef enum logic [2:0] {
    CAUSE_POR = 3'h0,
    CAUSE_CLR_RUN = 3'h1,
    CAUSE_CLR_SLEEP = 3'h2,
    CAUSE_WDOG = 3'h3,
    CAUSE_WDOG_WAKE = 3'h4,
    CAUSE_BROWN = 3'h5,
    CAUSE_INT_WAKE = 3'h6
  } rst_cause_t;

  typedef enum logic [2:0] {ST_BOOT, ST_PUT, ST_SUT, ST_HOLD, ST_RUN, ST_SLEEP} rst_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rst_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } rst_apb_rsp_t;

  typedef struct packed {
    rst_state_t state;
    rst_cause_t cause;
    logic tmo_n;
    logic pdown_n;
    logic [CNT_W-1:0] cnt;
    logic [SUT_W-1:0] sut;
    logic [FILT_W-1:0] filt;
    logic [3:0] cfg;
    logic [31:0] prdata;
    logic pslverr;
    logic [PIN_N-1:0] s1;
    logic [PIN_N-1:0] s2;
    logic [2:0] prev;
    logic core_rst;
    logic reg_init;
    logic wake;
  } rst_regs_t;
endpackage : rst_pkg

// ==== hdl/rst_sequencer.sv ====
// reset and start-up sequencer: cause detection, clear filter, power-up and start-up timers
// assumes pins are asynchronous to sys_clk and sleep_req/int_wake come from the core on sys_clk
`timescale 1ns/1ps
`default_nettype none
module rst_sequencer #(
  parameter int PUT_TICKS = rst_pkg::PUT_TICKS,
  parameter int SUT_CYCLES = rst_pkg::SUT_CYCLES,
  parameter int FILT_TICKS = rst_pkg::FILT_TICKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // apb slave
  input wire rst_pkg::rst_apb_req_t apb_req,
  output rst_pkg::rst_apb_rsp_t apb_rsp,
  // external clear pin, open drain
  input wire logic external_clear_n_i,
  output logic external_clear_n_o,
  output logic external_clear_n_oe_n,
  // oscillator and supply monitors
  input wire logic osc_input_pin,
  input wire logic rc_osc_clk,
  input wire logic supply_rise,
  input wire logic brown_out_reset,
  input wire logic watchdog_timeout,
  // core side
  input wire logic sleep_req,
  input wire logic int_wake,
  output logic core_reset,
  output logic reg_init,
  output logic wake_pulse,
  output logic timeout_flag_n,
  output logic power_down_flag_n
);
  logic [1:0] rst_sync_q;
  logic rst_n_s;
  rst_pkg::rst_regs_t r_q;
  rst_pkg::rst_regs_t r_d;
  logic rc_edge;
  logic osc_edge;
  logic por_ev;
  logic clr_ev;
  logic clr_held;
  logic wdog_ev;
  logic brown_ev;
  logic put_on;
  logic crystal;
  logic setup;
  logic access;
  localparam int CNT_W = rst_pkg::CNT_W;
  localparam int SUT_W = rst_pkg::SUT_W;
  localparam int FILT_W = rst_pkg::FILT_W;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sync_q[1];

  function automatic logic is_crystal(input logic [1:0] sel);
    is_crystal = (rst_pkg::rst_osc_mode_t'(sel) != rst_pkg::OSC_RC);
  endfunction : is_crystal

  always_comb
  begin
    r_d = r_q;
    r_d.reg_init = 1'b0;
    r_d.wake = 1'b0;
    // pin synchronisers, external clock or crystal on the oscillator pin alike
    r_d.s1 = {supply_rise, brown_out_reset, watchdog_timeout, osc_input_pin, rc_osc_clk, external_clear_n_i};
    r_d.s2 = r_q.s1;
    r_d.prev = {r_q.s2[rst_pkg::PIN_SUP], r_q.s2[rst_pkg::PIN_OSC], r_q.s2[rst_pkg::PIN_RC]};
    rc_edge = r_q.s2[rst_pkg::PIN_RC] & ~r_q.prev[0];
    osc_edge = r_q.s2[rst_pkg::PIN_OSC] & ~r_q.prev[1];
    por_ev = (r_q.s2[rst_pkg::PIN_SUP] & ~r_q.prev[2]) | (r_q.state == rst_pkg::ST_BOOT);
    brown_ev = r_q.s2[rst_pkg::PIN_BROWN] & r_q.cfg[rst_pkg::CFG_BROWN_EN];
    wdog_ev = r_q.s2[rst_pkg::PIN_WDOG];
    put_on = ~r_q.cfg[rst_pkg::CFG_PUT_EN_N] | r_q.cfg[rst_pkg::CFG_BROWN_EN];
    crystal = is_crystal(r_q.cfg[rst_pkg::CFG_OSC_LO +: 2]);
    // clear filter: low for FILT_TICKS rc ticks before it counts
    clr_ev = 1'b0;
    if (r_q.s2[rst_pkg::PIN_CLR])
    begin
      r_d.filt = '0;
    end
    else if (rc_edge && (r_q.filt != FILT_W'(FILT_TICKS)))
    begin
      r_d.filt = r_q.filt + 1'b1;
      clr_ev = (r_d.filt == FILT_W'(FILT_TICKS));
    end
    clr_held = (r_d.filt == FILT_W'(FILT_TICKS));
    // cause detection, power-on first
    if (por_ev)
    begin
      r_d.cause = rst_pkg::CAUSE_POR;
      {r_d.tmo_n, r_d.pdown_n} = 2'h3;
      r_d.reg_init = 1'b1;
      r_d.cnt = '0;
      r_d.sut = '0;
      r_d.state = put_on ? rst_pkg::ST_PUT : (crystal ? rst_pkg::ST_SUT : rst_pkg::ST_HOLD);
    end
    else if (brown_ev)
    begin
      r_d.cause = rst_pkg::CAUSE_BROWN;
      {r_d.tmo_n, r_d.pdown_n} = 2'h3;
      r_d.reg_init = 1'b1;
      r_d.cnt = '0;
      r_d.state = rst_pkg::ST_PUT;
    end
    else if (clr_ev && (r_q.state == rst_pkg::ST_RUN || r_q.state == rst_pkg::ST_SLEEP))
    begin
      r_d.reg_init = 1'b1;
      r_d.state = rst_pkg::ST_HOLD;
      if (r_q.state == rst_pkg::ST_SLEEP)
      begin
        r_d.cause = rst_pkg::CAUSE_CLR_SLEEP;
        {r_d.tmo_n, r_d.pdown_n} = 2'h2;
      end
      else
      begin
        r_d.cause = rst_pkg::CAUSE_CLR_RUN; // flags unchanged
      end
    end
    else if (wdog_ev && r_q.state == rst_pkg::ST_RUN)
    begin
      r_d.cause = rst_pkg::CAUSE_WDOG;
      {r_d.tmo_n, r_d.pdown_n} = 2'h1;
      r_d.reg_init = 1'b1; // internal only, pin untouched
      r_d.state = rst_pkg::ST_HOLD;
    end
    else if ((wdog_ev || int_wake) && r_q.state == rst_pkg::ST_SLEEP)
    begin
      r_d.cause = wdog_ev ? rst_pkg::CAUSE_WDOG_WAKE : rst_pkg::CAUSE_INT_WAKE;
      {r_d.tmo_n, r_d.pdown_n} = wdog_ev ? 2'h0 : 2'h2;
      r_d.wake = 1'b1; // no reset load on wake
      r_d.sut = '0;
      r_d.state = crystal ? rst_pkg::ST_SUT : rst_pkg::ST_RUN;
    end
    else
    begin
      unique case (r_q.state)
        rst_pkg::ST_BOOT:
        begin
          r_d.state = rst_pkg::ST_BOOT;
        end
        rst_pkg::ST_PUT:
        begin
          if (rc_edge)
          begin
            r_d.cnt = r_q.cnt + 1'b1;
            if (r_q.cnt == CNT_W'(PUT_TICKS - 1))
            begin
              r_d.sut = '0;
              r_d.state = (crystal && r_q.cause == rst_pkg::CAUSE_POR) ? rst_pkg::ST_SUT : rst_pkg::ST_HOLD;
            end
          end
        end
        rst_pkg::ST_SUT:
        begin
          if (osc_edge)
          begin
            r_d.sut = r_q.sut + 1'b1;
            if (r_q.sut == SUT_W'(SUT_CYCLES - 1))
            begin
              r_d.state = (r_q.cause == rst_pkg::CAUSE_POR) ? rst_pkg::ST_HOLD : rst_pkg::ST_RUN;
            end
          end
        end
        rst_pkg::ST_HOLD:
        begin
          if (!clr_held)
          begin
            r_d.state = rst_pkg::ST_RUN;
          end
        end
        rst_pkg::ST_RUN:
        begin
          if (sleep_req)
          begin
            {r_d.tmo_n, r_d.pdown_n} = 2'h2;
            r_d.state = rst_pkg::ST_SLEEP;
          end
        end
        rst_pkg::ST_SLEEP:
        begin
          r_d.state = rst_pkg::ST_SLEEP;
        end
        default:
        begin
          r_d.state = rst_pkg::ST_BOOT;
        end
      endcase
    end
    r_d.core_rst = (r_d.state != rst_pkg::ST_RUN) && (r_d.state != rst_pkg::ST_SLEEP);
    // apb: decode in setup, data out in access
    setup = apb_req.psel & ~apb_req.penable;
    access = apb_req.psel & apb_req.penable;
    if (setup)
    begin
      r_d.prdata = '0;
      r_d.pslverr = 1'b0;
      if (apb_req.paddr == rst_pkg::ADDR_CFG)
      begin
        r_d.prdata[3:0] = r_q.cfg;
      end
      else if (apb_req.paddr == rst_pkg::ADDR_STATUS)
      begin
        r_d.prdata[rst_pkg::ST_PDOWN] = r_q.pdown_n;
        r_d.prdata[rst_pkg::ST_TMO] = r_q.tmo_n;
        r_d.prdata[rst_pkg::ST_CAUSE +: 3] = r_q.cause;
        r_d.prdata[rst_pkg::ST_INRST] = r_q.core_rst;
      end
      else
      begin
        r_d.pslverr = 1'b1;
      end
    end
    if (access && apb_req.pwrite && apb_req.paddr == rst_pkg::ADDR_CFG)
    begin
      r_d.cfg = apb_req.pwdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_s)
  begin
    if (!rst_n_s)
    begin
      r_q <= '{state: rst_pkg::ST_BOOT, cause: rst_pkg::CAUSE_POR, tmo_n: 1'b1, pdown_n: 1'b1,
               cfg: rst_pkg::CFG_RST, core_rst: 1'b1, default: '0};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = r_q.pslverr & apb_req.psel & apb_req.penable;
  assign apb_rsp.prdata = r_q.prdata;
  assign external_clear_n_o = 1'b0;
  assign external_clear_n_oe_n = 1'b1;
  assign core_reset = r_q.core_rst;
  assign reg_init = r_q.reg_init; // registers without reset ignore this
  assign wake_pulse = r_q.wake;
  assign timeout_flag_n = r_q.tmo_n;
  assign power_down_flag_n = r_q.pdown_n;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n_s);

  a_wake_no_init: assert property (r_q.wake |-> !r_q.reg_init) else $error("wake loaded reset state");
  a_timer_in_reset: assert property (r_q.state inside {rst_pkg::ST_PUT, rst_pkg::ST_SUT} |-> core_reset)
    else $error("core left reset during timer");
  a_sut_crystal_only: assert property ($rose(r_q.state == rst_pkg::ST_SUT) |-> $past(crystal))
    else $error("start-up count in rc mode");
  a_put_cause: assert property (r_q.state == rst_pkg::ST_PUT |-> r_q.cause inside {rst_pkg::CAUSE_POR, rst_pkg::CAUSE_BROWN})
    else $error("power-up timer after wrong cause");
  a_put_length: assert property ($rose(r_q.state == rst_pkg::ST_SUT) && $past(r_q.state) == rst_pkg::ST_PUT
    |-> $past(r_q.cnt) == CNT_W'(PUT_TICKS - 1)) else $error("power-up delay length wrong");
  a_por_flags: assert property (r_q.reg_init && r_q.cause == rst_pkg::CAUSE_POR |-> r_q.tmo_n && r_q.pdown_n)
    else $error("power-on flags wrong");
  a_wdog_flags: assert property (r_q.reg_init && r_q.cause == rst_pkg::CAUSE_WDOG |-> !r_q.tmo_n && r_q.pdown_n)
    else $error("watchdog flags wrong");
  a_clr_run_keep: assert property (r_q.reg_init && r_q.cause == rst_pkg::CAUSE_CLR_RUN
    |-> $stable(r_q.tmo_n) && $stable(r_q.pdown_n)) else $error("clear in run changed flags");
  a_clr_filtered: assert property (r_q.reg_init && r_q.cause inside {rst_pkg::CAUSE_CLR_RUN, rst_pkg::CAUSE_CLR_SLEEP}
    |-> r_q.filt == FILT_W'(FILT_TICKS)) else $error("clear taken before filter time");
  a_pin_released: assert property (external_clear_n_oe_n) else $error("clear pin driven");

  c_por_to_run: cover property ($rose(r_q.state == rst_pkg::ST_RUN) && r_q.cause == rst_pkg::CAUSE_POR);
  c_wdog_wake: cover property (r_q.wake && r_q.cause == rst_pkg::CAUSE_WDOG_WAKE);
  c_clr_sleep: cover property (r_q.reg_init && r_q.cause == rst_pkg::CAUSE_CLR_SLEEP);
  c_brown: cover property (r_q.reg_init && r_q.cause == rst_pkg::CAUSE_BROWN);
endmodule : rst_sequencer
`default_nettype wire

// ==== dv/rst_pin_partner.sv ====
// partner model: external clock on the oscillator input, internal rc clock and the clear pin
// assumes the bench pulls the clear pin low through clr_low; the pin has a pull-up
`timescale 1ns/1ps
`default_nettype none
module rst_pin_partner #(
  parameter int OSC_HALF_NS = 100,
  parameter int RC_HALF_NS = 400
) (
  // bench control
  input wire logic clr_low,
  // device side of the clear pin
  input wire logic clr_o,
  input wire logic clr_oe_n,
  output logic clr_pin,
  // clock sources
  output logic osc_pin,
  output logic rc_clk
);
  initial
  begin
    osc_pin = 1'b0;
    forever #(OSC_HALF_NS) osc_pin = ~osc_pin;
  end
  initial
  begin
    rc_clk = 1'b0;
    forever #(RC_HALF_NS) rc_clk = ~rc_clk;
  end
  // pull-up wins unless someone drives low
  assign clr_pin = (clr_low || (!clr_oe_n && !clr_o)) ? 1'b0 : 1'b1;
endmodule : rst_pin_partner
`default_nettype wire

// ==== dv/tb.sv ====
// testbench for the reset sequencer: power-on, brown-out, watchdog, clear and sleep paths
// assumes short timer parameters and the pin partner for clocks and the clear pin
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk, resetn, sup, brown, wdog, slp, iwk, clr_low, e;
  logic core_reset, reg_init, wake_pulse, tmo_n, pdown_n, clr_o, clr_oe_n, clr_pin, osc, rc;
  logic [31:0] q;
  rst_pkg::rst_apb_req_t req;
  rst_pkg::rst_apb_rsp_t rsp;
  int fails, checks, cyc, n_init, n_wake, n_drv;
  rst_sequencer #(.PUT_TICKS(8), .SUT_CYCLES(4), .FILT_TICKS(4)) u_rst_sequencer (
    .sys_clk(sys_clk), .resetn(resetn), .apb_req(req), .apb_rsp(rsp), .external_clear_n_i(clr_pin),
    .external_clear_n_o(clr_o), .external_clear_n_oe_n(clr_oe_n), .osc_input_pin(osc), .rc_osc_clk(rc),
    .supply_rise(sup), .brown_out_reset(brown), .watchdog_timeout(wdog), .sleep_req(slp), .int_wake(iwk),
    .core_reset(core_reset), .reg_init(reg_init), .wake_pulse(wake_pulse), .timeout_flag_n(tmo_n),
    .power_down_flag_n(pdown_n));
  rst_pin_partner u_rst_pin_partner (.clr_low(clr_low), .clr_o(clr_o), .clr_oe_n(clr_oe_n),
    .clr_pin(clr_pin), .osc_pin(osc), .rc_clk(rc));
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    n_init += (reg_init === 1'b1);
    n_wake += (wake_pulse === 1'b1);
    n_drv += (clr_oe_n !== 1'b1);
    if (cyc == 30000)
    begin
      fails++;
      complete_run();
    end
  end
  task complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (rsp.pready !== 1'b1 && n < 20);
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    check("pready", n < 20, 1);
  endtask : apb
  task st_chk(input logic [2:0] cause, input logic t, input logic p);
    apb(1'b0, rst_pkg::ADDR_STATUS, 32'h0);
    check("status", q, {27'h0, cause, t, p});
    check("flag pins", {tmo_n, pdown_n}, {t, p});
  endtask : st_chk
  task wait_rst(output int c);
    c = 0;
    while (core_reset !== 1'b1 && c < 40)
    begin
      @(posedge sys_clk);
      c++;
    end
    while (core_reset !== 1'b0 && c < 400)
    begin
      @(posedge sys_clk);
      c++;
    end
  endtask : wait_rst
  task wait_wake(input int w0);
    int n;
    n = 0;
    while (n_wake == w0 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    check("wake pulse", n_wake > w0, 1);
  endtask : wait_wake
  task t_regs();
    apb(1'b0, rst_pkg::ADDR_CFG, 32'h0);
    check("cfg reset", q, 32'h7);
    st_chk(rst_pkg::CAUSE_POR, 1'b1, 1'b1);
    apb(1'b1, rst_pkg::ADDR_STATUS, 32'hFFFFFFFF);
    st_chk(rst_pkg::CAUSE_POR, 1'b1, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check("unmapped err", e, 1'b1);
    check("unmapped data", q, 32'h0);
    apb(1'b1, rst_pkg::ADDR_CFG, 32'h2);
    apb(1'b0, rst_pkg::ADDR_CFG, 32'h0);
    check("cfg write", q, 32'h2);
  endtask : t_regs
  task t_por(input logic [3:0] cfg, input int lo, input int hi);
    int c, n0;
    n0 = n_init;
    apb(1'b1, rst_pkg::ADDR_CFG, {28'h0, cfg});
    @(posedge sys_clk);
    sup <= 1'b1;
    wait_rst(c);
    sup <= 1'b0;
    check("por hold time", c >= lo && c <= hi, 1);
    check("por init", n_init > n0, 1);
    st_chk(rst_pkg::CAUSE_POR, 1'b1, 1'b1);
  endtask : t_por
  task t_brown();
    int c;
    apb(1'b1, rst_pkg::ADDR_CFG, 32'h7);
    @(posedge sys_clk);
    brown <= 1'b1;
    repeat (3) @(posedge sys_clk);
    brown <= 1'b0;
    repeat (10) @(posedge sys_clk);
    check("brown-out off", core_reset, 1'b0);
    apb(1'b1, rst_pkg::ADDR_CFG, 32'hF);
    @(posedge sys_clk);
    brown <= 1'b1;
    repeat (3) @(posedge sys_clk);
    brown <= 1'b0;
    wait_rst(c);
    check("brown-out hold time", c >= 100 && c <= 155, 1);
    st_chk(rst_pkg::CAUSE_BROWN, 1'b1, 1'b1);
    apb(1'b1, rst_pkg::ADDR_CFG, 32'h3);
  endtask : t_brown
  task t_wdog();
    int c, n0;
    n0 = n_init;
    @(posedge sys_clk);
    wdog <= 1'b1;
    @(posedge sys_clk);
    wdog <= 1'b0;
    wait_rst(c);
    check("watchdog short", c < 20, 1);
    check("watchdog init", n_init > n0, 1);
    st_chk(rst_pkg::CAUSE_WDOG, 1'b0, 1'b1);
  endtask : t_wdog
  task clear_long();
    int c;
    @(posedge sys_clk);
    clr_low <= 1'b1;
    repeat (100) @(posedge sys_clk);
    check("clear held", core_reset, 1'b1);
    clr_low <= 1'b0;
    wait_rst(c);
  endtask : clear_long
  task t_clr();
    @(posedge sys_clk);
    clr_low <= 1'b1;
    repeat (24) @(posedge sys_clk);
    clr_low <= 1'b0;
    repeat (12) @(posedge sys_clk);
    check("short clear", core_reset, 1'b0);
    clear_long();
    st_chk(rst_pkg::CAUSE_CLR_RUN, 1'b0, 1'b1);
  endtask : t_clr
  task go_sleep();
    @(posedge sys_clk);
    slp <= 1'b1;
    @(posedge sys_clk);
    slp <= 1'b0;
    repeat (6) @(posedge sys_clk);
    check("sleep flags", {tmo_n, pdown_n}, 2'h2);
  endtask : go_sleep
  task t_sleep();
    int w0, n0;
    go_sleep();
    w0 = n_wake;
    n0 = n_init;
    @(posedge sys_clk);
    wdog <= 1'b1;
    @(posedge sys_clk);
    wdog <= 1'b0;
    wait_wake(w0);
    st_chk(rst_pkg::CAUSE_WDOG_WAKE, 1'b0, 1'b0);
    check("wake no init", n_init, n0);
    go_sleep();
    w0 = n_wake;
    @(posedge sys_clk);
    iwk <= 1'b1;
    @(posedge sys_clk);
    iwk <= 1'b0;
    wait_wake(w0);
    st_chk(rst_pkg::CAUSE_INT_WAKE, 1'b1, 1'b0);
    go_sleep();
    n0 = n_init;
    clear_long();
    st_chk(rst_pkg::CAUSE_CLR_SLEEP, 1'b1, 1'b0);
    check("sleep clear init", n_init > n0, 1);
  endtask : t_sleep
  initial
  begin
    int c;
    {resetn, sup, brown, wdog, slp, iwk, clr_low} = 7'h0;
    req = '0;
    {fails, checks, cyc, n_init, n_wake, n_drv} = '0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    wait_rst(c);
    t_regs();
    t_por(4'h3, 105, 155);
    t_por(4'h7, 0, 12);
    for (int m = 0; m < 3; m++)
      t_por(4'h4 | m[3:0], 10, 32);
    t_por(4'h1, 120, 175);
    t_brown();
    t_wdog();
    t_clr();
    t_sleep();
    check("clear pin driven", n_drv, 0);
    complete_run();
  end
endmodule : tb
`default_nettype wire
